// file: inc/ppc_pkg.sv
// Shared constants and types for the transceiver pin configuration block.
// Assumes a 20 MHz system clock and a 32-bit APB register bus.
package ppc_pkg;

   localparam int CLK_PERIOD_NS = 50;

   // Register indices as printed; byte address is four times the index
   localparam logic [7:0] IDX_CTRL = 8'h00;
   localparam logic [7:0] IDX_IND = 8'h1e;
   localparam logic [7:0] IDX_STAT = 8'h1f;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_IND = 8'h78;
   localparam logic [7:0] ADDR_STAT = 8'h7c;

   // Field positions
   localparam int CTRL_SPEED_BIT = 13;
   localparam int IND_MODE_HI = 15;
   localparam int IND_MODE_LO = 14;
   localparam int STAT_ADDR_LO = 0;
   localparam int STAT_IFSEL_LO = 5;
   localparam int STAT_RMII_BIT = 8;
   localparam int STAT_RSVD_BIT = 9;
   localparam int STAT_BADADDR_BIT = 10;
   localparam int STAT_PREAMBLE_BIT = 11;
   localparam int STAT_DONE_BIT = 12;

   // Values after reset
   localparam logic [1:0] IND_MODE_RESET = 2'h0;
   localparam logic [1:0] STATION_UPPER = 2'h0;
   localparam logic [31:0] PRDATA_RESET = 32'h0000_0000;

   // Indicator modes
   localparam logic [1:0] IND_SPEED = 2'h0;
   localparam logic [1:0] IND_ACTIVITY = 2'h1;

   // Interface-select codes
   localparam logic [2:0] IFSEL_MII = 3'h0;
   localparam logic [2:0] IFSEL_RMII = 3'h1;
   localparam logic [2:0] IFSEL_MII_PRE = 3'h4;

   // Activity blink period
   localparam int BLINK_TIME_MS = 50;
   localparam int BLINK_CYCLES = BLINK_TIME_MS * 1000000 / CLK_PERIOD_NS;

   typedef enum logic [0:0] {
      SS_SAMPLE = 1'b0,
      SS_RUN = 1'b1
   } ppc_strap_state_t;

   typedef struct packed {
      logic speed;
      logic [2:0] stationId;
      logic [2:0] ifSel;
   } ppc_strap_t;

   typedef struct packed {
      logic en;
      logic [3:0] data;
   } ppc_mii_t;

endpackage

// file: hw/ppc_sync2.sv
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes each bit is independent; groups are realigned by the reader.
`timescale 1ns/1ps
module ppc_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
      end
      else
      begin
         meta_reg <= asyncIn;
         sync_reg <= meta_reg;
      end
   end

   assign syncOut = sync_reg;
endmodule // ppc_sync2

// file: hw/ppc_pin_cfg.sv
// Strap capture, speed/activity indicator and MII/RMII data pins of a 10/100 PHY.
// Assumes link clock and all pins are asynchronous to sys_clk and much slower.
// Notes on behaviour
// - Speed strap level is loaded into control register bit 13 at reset.
// - Indicator mode bits 15:14: 00 speed, 01 activity toggle, 11 reserved.
// - Strap pins are inputs during reset and driven outputs afterwards.
// - MII receive nibble follows link clock, valid only with data valid.
// - RMII sends two recovered bits per reference clock while data valid.
// - MII transmit nibbles accepted only while transmit enable is high.
// - RMII transmit captures two bits per reference clock with enable.
// - Transmit and receive data change in step with their link clock.
// - Three station-address straps latched at reset; 1 to 7 allowed.
// - Station address upper two bits are always zero.
// - Interface-select straps latched: 000 MII default, 001 RMII.
// - Code 100 is MII with preamble restore; other codes reserved. Here 100 runs as plain MII and only sets status bit 11.
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
module ppc_pin_cfg
   import ppc_pkg::*;
#(
   parameter int BLINK_CYC = BLINK_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Chip pins
   input wire logic chipResetN,
   input wire logic linkClk,
   input wire logic speedIndIn,
   output logic speed_activity_indicator,
   output logic speedIndOe,
   input wire logic [2:0] stationStrapIn,
   output logic [2:0] stationStrapOut,
   output logic [2:0] stationStrapOe,
   input wire logic [2:0] ifSelStrapIn,
   output logic [2:0] ifSelStrapOut,
   output logic [2:0] ifSelStrapOe,
   output logic [3:0] rxData,
   output logic rxValid,
   input wire logic [3:0] txData,
   input wire logic txEnable,
   // Core side
   input wire logic [3:0] recvData,
   input wire logic recvValid,
   output logic recvTake,
   output logic [3:0] txCapData,
   output logic txCapValid,
   output logic [4:0] stationAddr,
   output logic rmiiMode
);
   localparam int SYNC_W = 14;

   logic [SYNC_W-1:0] syncIn;
   logic [SYNC_W-1:0] syncOut;
   logic chipResetNSync;
   logic linkClkSync;
   ppc_strap_t strapSync;
   ppc_mii_t txSync;

   assign syncIn = {chipResetN, linkClk, speedIndIn, stationStrapIn, ifSelStrapIn,
                    txEnable, txData};

   ppc_sync2 #(
      .WIDTH(SYNC_W)
   ) u_sync (
      .clk(sys_clk),
      .rst(rst),
      .asyncIn(syncIn),
      .syncOut(syncOut)
   );

   assign chipResetNSync = syncOut[13];
   assign linkClkSync = syncOut[12];
   assign strapSync = syncOut[11:5];
   assign txSync = syncOut[4:0];

   // Strap capture
   ppc_strap_state_t strapState_reg, strapState_next;
   ppc_strap_t strap_reg, strap_next;
   logic speedSel_reg, speedSel_next;
   logic [1:0] indMode_reg, indMode_next;
   logic wrCtrl;
   logic wrInd;

   always_comb
   begin
      strapState_next = strapState_reg;
      strap_next = strap_reg;
      speedSel_next = speedSel_reg;
      indMode_next = indMode_reg;
      case (strapState_reg)
         SS_SAMPLE:
         begin
            strap_next = strapSync;
            speedSel_next = strapSync.speed;
            // leave only on chip reset release
            if (chipResetNSync)
               strapState_next = SS_RUN;
         end
         SS_RUN:
         begin
            if (!chipResetNSync)
            begin
               strapState_next = SS_SAMPLE;
               indMode_next = IND_MODE_RESET;
            end
            else
            begin
               if (wrCtrl)
                  speedSel_next = pwdata[CTRL_SPEED_BIT];
               if (wrInd)
                  indMode_next = pwdata[IND_MODE_HI:IND_MODE_LO];
            end
         end
         default:
            strapState_next = SS_SAMPLE;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         strapState_reg <= SS_SAMPLE;
         strap_reg <= '0;
         speedSel_reg <= 1'b0;
         indMode_reg <= IND_MODE_RESET;
      end
      else
      begin
         strapState_reg <= strapState_next;
         strap_reg <= strap_next;
         speedSel_reg <= speedSel_next;
         indMode_reg <= indMode_next;
      end
   end

   logic running;
   logic rmiiSel;
   logic ifReserved;
   logic badAddr;
   assign running = (strapState_reg == SS_RUN);
   // code 100 stays MII, reserved codes fall back to MII
   assign rmiiSel = (strap_reg.ifSel == IFSEL_RMII);
   assign ifReserved = (strap_reg.ifSel != IFSEL_MII) && (strap_reg.ifSel != IFSEL_RMII) &&
                       (strap_reg.ifSel != IFSEL_MII_PRE);
   // address 0 flagged as not allowed
   assign badAddr = (strap_reg.stationId == 3'h0);

   // Link clock edges
   logic linkPrev_reg;
   logic linkRise;
   logic linkFall;
   assign linkRise = linkClkSync & ~linkPrev_reg;
   assign linkFall = ~linkClkSync & linkPrev_reg;

   // Receive path
   ppc_mii_t rx_reg, rx_next;
   logic rxPhase_reg, rxPhase_next;
   logic take_reg, take_next;

   always_comb
   begin
      rx_next = rx_reg;
      rxPhase_next = rxPhase_reg;
      take_next = 1'b0;
      if (!running)
      begin
         rx_next = '0;
         rxPhase_next = 1'b0;
      end
      // receive pins change only after a link clock edge
      else if (linkRise)
      begin
         if (!recvValid)
         begin
            // data forced idle when not valid
            rx_next = '0;
            rxPhase_next = 1'b0;
         end
         else if (!rmiiSel)
         begin
            // one nibble per clock with valid
            rx_next.en = 1'b1;
            rx_next.data = recvData;
            take_next = 1'b1;
         end
         else
         begin
            // two bits per reference clock, low pair first
            rx_next.en = 1'b1;
            rx_next.data = rxPhase_reg ? {2'h0, recvData[3:2]} : {2'h0, recvData[1:0]};
            rxPhase_next = ~rxPhase_reg;
            take_next = rxPhase_reg;
         end
      end
   end

   // Transmit path
   ppc_mii_t txCap_reg, txCap_next;
   logic [1:0] txLow_reg, txLow_next;
   logic txPhase_reg, txPhase_next;

   always_comb
   begin
      txCap_next = txCap_reg;
      txCap_next.en = 1'b0;
      txLow_next = txLow_reg;
      txPhase_next = txPhase_reg;
      // sampled mid-period, away from the edge the MAC changes on
      if (!running)
         txPhase_next = 1'b0;
      else if (linkFall)
      begin
         if (!txSync.en)
            txPhase_next = 1'b0;
         else if (!rmiiSel)
         begin
            txCap_next.en = 1'b1;
            txCap_next.data = txSync.data;
         end
         // two bits captured per reference clock
         else if (!txPhase_reg)
         begin
            txLow_next = txSync.data[1:0];
            txPhase_next = 1'b1;
         end
         else
         begin
            txCap_next.en = 1'b1;
            txCap_next.data = {txSync.data[1:0], txLow_reg};
            txPhase_next = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         linkPrev_reg <= 1'b0;
         rx_reg <= '0;
         rxPhase_reg <= 1'b0;
         take_reg <= 1'b0;
         txCap_reg <= '0;
         txLow_reg <= 2'h0;
         txPhase_reg <= 1'b0;
      end
      else
      begin
         linkPrev_reg <= linkClkSync;
         rx_reg <= rx_next;
         rxPhase_reg <= rxPhase_next;
         take_reg <= take_next;
         txCap_reg <= txCap_next;
         txLow_reg <= txLow_next;
         txPhase_reg <= txPhase_next;
      end
   end

   // Indicator output; the blink counter is free running to save an enable path
   logic [31:0] blinkCnt_reg, blinkCnt_next;
   logic actSeen_reg, actSeen_next;
   logic blink_reg, blink_next;
   logic ind_reg, ind_next;
   logic wrap;
   assign wrap = (blinkCnt_reg == 32'(BLINK_CYC - 1));

   always_comb
   begin
      blinkCnt_next = wrap ? 32'h0 : blinkCnt_reg + 32'h1;
      // Activity seen in the same cycle as the wrap is kept
      actSeen_next = (rx_reg.en | txSync.en) | (actSeen_reg & ~wrap);
      blink_next = blink_reg;
      if (wrap)
         blink_next = actSeen_reg ? ~blink_reg : 1'b1;
      case (indMode_reg)
         // low at 100 Mbps, high at 10 Mbps
         IND_SPEED:
            ind_next = ~speedSel_reg;
         // high when idle, toggles on activity
         IND_ACTIVITY:
            ind_next = blink_reg;
         default:
            ind_next = 1'b1;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         blinkCnt_reg <= 32'h0;
         actSeen_reg <= 1'b0;
         blink_reg <= 1'b1;
         ind_reg <= 1'b1;
      end
      else
      begin
         blinkCnt_reg <= blinkCnt_next;
         actSeen_reg <= actSeen_next;
         blink_reg <= blink_next;
         ind_reg <= ind_next;
      end
   end

   // APB slave, one wait state per access
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic access;
   logic hitCtrl;
   logic hitInd;
   logic hitStat;
   logic [15:0] statWord;

   assign access = psel & penable & ~pready_reg;
   assign hitCtrl = (paddr == ADDR_CTRL);
   assign hitInd = (paddr == ADDR_IND);
   assign hitStat = (paddr == ADDR_STAT);
   assign wrCtrl = access & pwrite & hitCtrl;
   assign wrInd = access & pwrite & hitInd;

   always_comb
   begin
      statWord = 16'h0;
      statWord[STAT_ADDR_LO +: 5] = {STATION_UPPER, strap_reg.stationId};
      statWord[STAT_IFSEL_LO +: 3] = strap_reg.ifSel;
      statWord[STAT_RMII_BIT] = rmiiSel;
      statWord[STAT_RSVD_BIT] = ifReserved;
      statWord[STAT_BADADDR_BIT] = badAddr;
      statWord[STAT_PREAMBLE_BIT] = (strap_reg.ifSel == IFSEL_MII_PRE);
      statWord[STAT_DONE_BIT] = running;
   end

   always_comb
   begin
      prdata_next = prdata_reg;
      pready_next = access;
      pslverr_next = 1'b0;
      if (access)
      begin
         prdata_next = PRDATA_RESET;
         if (hitCtrl)
            prdata_next[CTRL_SPEED_BIT] = speedSel_reg;
         else if (hitInd)
            prdata_next[IND_MODE_HI:IND_MODE_LO] = indMode_reg;
         else if (hitStat)
            prdata_next[15:0] = statWord;
         else
            pslverr_next = 1'b1;
         if (pwrite && hitStat)
            pslverr_next = 1'b1;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         prdata_reg <= PRDATA_RESET;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end
      else
      begin
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // Pin drivers; strap pins float while sampling
   logic pinOe_reg;
   logic [4:0] addr_reg;
   logic rmii_reg;

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         pinOe_reg <= 1'b0;
         addr_reg <= 5'h0;
         rmii_reg <= 1'b0;
      end
      else
      begin
         // drive only once reset is over
         pinOe_reg <= running;
         addr_reg <= {STATION_UPPER, strap_reg.stationId};
         rmii_reg <= rmiiSel;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign speed_activity_indicator = ind_reg;
   assign speedIndOe = pinOe_reg;
   assign stationStrapOut = 3'h0;
   assign stationStrapOe = {3{pinOe_reg}};
   assign ifSelStrapOut = 3'h0;
   assign ifSelStrapOe = {3{pinOe_reg}};
   assign rxData = rx_reg.data;
   assign rxValid = rx_reg.en;
   assign recvTake = take_reg;
   assign txCapData = txCap_reg.data;
   assign txCapValid = txCap_reg.en;
   assign stationAddr = addr_reg;
   assign rmiiMode = rmii_reg;
endmodule // ppc_pin_cfg

// file: verif/ppc_pin_cfg_sva.sv
// Concurrent checks on the pin configuration block's ports.
// Assumes one sys_clk domain with synchronous active-high rst.
`timescale 1ns/1ps
module ppc_pin_cfg_sva
   import ppc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic chipResetN,
   input wire logic speedIndOe,
   input wire logic [2:0] stationStrapOut,
   input wire logic [2:0] stationStrapOe,
   input wire logic [2:0] ifSelStrapOut,
   input wire logic [2:0] ifSelStrapOe,
   input wire logic [3:0] rxData,
   input wire logic rxValid,
   input wire logic txEnable,
   input wire logic [3:0] recvData,
   input wire logic recvTake,
   input wire logic txCapValid,
   input wire logic [4:0] stationAddr,
   input wire logic rmiiMode
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   sequence s_setup;
      psel && !penable ##1 psel && penable;
   endsequence
   // Four low samples leave room for the two-flop synchroniser
   sequence s_chip_low;
      !chipResetN [*4];
   endsequence
   apb_wait_a: assert property (s_setup |=> pready)
      else $error("pready not one cycle after access");
   oe_release_a: assert property (s_chip_low |=> !speedIndOe && stationStrapOe == 3'h0
      && ifSelStrapOe == 3'h0) else $error("strap pin driven during chip reset");
   strap_drive_a: assert property (stationStrapOut == 3'h0 && ifSelStrapOut == 3'h0)
      else $error("strap output value not zero");
   // Six high samples cover the synchroniser and the state change
   oe_drive_a: assert property (chipResetN [*6] |=> speedIndOe && stationStrapOe == 3'h7
      && ifSelStrapOe == 3'h7) else $error("strap pin not driven after chip reset");
   rx_invalid_a: assert property (!rxValid |-> rxData == 4'h0)
      else $error("receive data not idle without valid");
   mii_take_a: assert property (recvTake && !rmiiMode |-> rxValid && rxData == recvData)
      else $error("MII receive nibble wrong");
   rmii_take_a: assert property (rmiiMode && recvTake |-> rxData == {2'h0, recvData[3:2]})
      else $error("RMII high pair wrong");
   tx_quiet_a: assert property (!txEnable [*6] |-> !txCapValid)
      else $error("capture without transmit enable");
   latch_stable_a: assert property (speedIndOe && $past(speedIndOe) |-> $stable(stationAddr))
      else $error("station address changed while running");
   upper_zero_a: assert property (stationAddr[4:3] == 2'h0)
      else $error("station address upper bits set");
   mode_stable_a: assert property (speedIndOe && $past(speedIndOe) |-> $stable(rmiiMode))
      else $error("interface mode changed while running");
endmodule // ppc_pin_cfg_sva
bind ppc_pin_cfg ppc_pin_cfg_sva u_ppc_pin_cfg_sva (.sys_clk, .rst, .psel, .penable, .pready,
   .chipResetN, .speedIndOe, .stationStrapOut, .stationStrapOe, .ifSelStrapOut, .ifSelStrapOe,
   .rxData, .rxValid, .txEnable, .recvData, .recvTake, .txCapValid, .stationAddr, .rmiiMode);

// file: verif/ppc_mac_model.sv
// MAC transmit side: sends queued nibbles on the transceiver's transmit pins.
// Assumes a free-running link clock; the bench fills q.
`timescale 1ns/1ps
module ppc_mac_model
(
   input wire logic linkClk,
   input wire logic rmii,
   output logic [3:0] txData,
   output logic txEnable
);
   logic [3:0] q[$];
   logic ph = 1'b0;
   initial
   begin
      txData = 4'h5;
      txEnable = 1'b0;
   end
   // data with enable, changed on link rise
   always @(posedge linkClk)
      if (q.size() == 0)
      begin
         txEnable <= 1'b0;
         // Idle data keeps moving so stale values never look valid
         txData <= ~txData;
         ph <= 1'b0;
      end
      else if (!rmii)
      begin
         txEnable <= 1'b1;
         txData <= q.pop_front();
      end
      else
      begin
         txEnable <= 1'b1;
         txData <= ph ? {2'h0, q[0][3:2]} : {2'h0, q[0][1:0]};
         if (ph)
            void'(q.pop_front());
         ph <= ~ph;
      end
endmodule // ppc_mac_model

// file: verif/tb_ppc_pin_cfg.sv
// Self-checking bench for the pin configuration block.
// Assumes a 20 MHz sys_clk and a free 400 ns link clock.
`timescale 1ns/1ps
module tb_ppc_pin_cfg
   import ppc_pkg::*;
;
   logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic chipResetN = 0, linkClk = 0, spdDrv = 1, speedIndIn, speedIndOe, err;
   logic speed_activity_indicator, rxValid, txEnable, recvValid = 0, recvTake;
   logic txCapValid, rmiiMode, lastInd;
   logic [2:0] stationStrapIn, stationStrapOut, stationStrapOe, stDrv = 3'h1;
   logic [2:0] ifSelStrapIn, ifSelStrapOut, ifSelStrapOe, ifDrv = 3'h0;
   logic [3:0] rxData, txData, recvData = 4'h0, txCapData, capQ[$], expQ[$];
   logic [4:0] stationAddr;
   logic [2:0] codes[5] = '{3'h0, 3'h1, 3'h4, 3'h2, 3'h7};
   int fails = 0, n_compared = 0, toggles = 0;
   always #25 sys_clk = ~sys_clk;
   always #200 linkClk = ~linkClk;
   assign speedIndIn = speedIndOe ? speed_activity_indicator : spdDrv;
   assign stationStrapIn = (stationStrapOe & stationStrapOut) | (~stationStrapOe & stDrv);
   assign ifSelStrapIn = (ifSelStrapOe & ifSelStrapOut) | (~ifSelStrapOe & ifDrv);
   ppc_pin_cfg #(.BLINK_CYC(16)) u_ppc_pin_cfg (.sys_clk, .rst, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .chipResetN, .linkClk, .speedIndIn,
      .speed_activity_indicator, .speedIndOe, .stationStrapIn, .stationStrapOut,
      .stationStrapOe, .ifSelStrapIn, .ifSelStrapOut, .ifSelStrapOe, .rxData, .rxValid,
      .txData, .txEnable, .recvData, .recvValid, .recvTake, .txCapData, .txCapValid,
      .stationAddr, .rmiiMode);
   ppc_mac_model u_ppc_mac_model (.linkClk, .rmii(rmiiMode), .txData, .txEnable);
   always @(posedge sys_clk)
   begin
      if (txCapValid === 1'b1)
         capQ.push_back(txCapData);
      if (speed_activity_indicator !== lastInd)
         toggles++;
      lastInd <= speed_activity_indicator;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      if (n >= 50)
         fails++;
   endtask
   function automatic logic [31:0] exp_stat(logic [2:0] c, logic [2:0] s);
      logic rsv;
      rsv = !(c == IFSEL_MII || c == IFSEL_RMII || c == IFSEL_MII_PRE);
      return {19'h0, 1'b1, c == IFSEL_MII_PRE, s == 3'h0, rsv, c == IFSEL_RMII, c, 2'h0, s};
   endfunction
   task automatic strap(input logic [2:0] c, input logic [2:0] s, input logic sp);
      @(posedge sys_clk);
      chipResetN <= 0;
      ifDrv <= c;
      stDrv <= s;
      spdDrv <= sp;
      repeat (8) @(posedge sys_clk);
      chipResetN <= 1;
      repeat (10) @(posedge sys_clk);
   endtask
   task automatic rx(input logic [3:0] d);
      int n;
      @(posedge sys_clk);
      recvData <= d;
      recvValid <= 1;
      n = 0;
      do
      begin
         @(negedge sys_clk);
         n++;
      end
      while (recvTake !== 1'b1 && n < 100);
      chk("rxData", rmiiMode ? {2'h0, d[3:2]} : d, rxData);
      chk("rxValid", 1, rxValid);
   endtask
   task automatic tx(input int n);
      int k;
      logic [3:0] v;
      capQ.delete();
      expQ.delete();
      repeat (n)
      begin
         v = 4'($urandom);
         expQ.push_back(v);
         u_ppc_mac_model.q.push_back(v);
      end
      k = 0;
      while (u_ppc_mac_model.q.size() > 0 && k < 2000)
      begin
         @(posedge sys_clk);
         k++;
      end
      repeat (40) @(posedge sys_clk);
      chk("txCount", n, capQ.size());
      foreach (expQ[i])
         chk("txCapData", expQ[i], capQ[i]);
   endtask
   initial
   begin
      #3000000;
      fails++;
      complete_run();
   end
   initial
   begin
      logic [2:0] sid;
      logic sp;
      void'($urandom(32'h06e9));
      repeat (16) @(posedge sys_clk);
      rst <= 0;
      foreach (codes[i])
      begin
         sid = (i == 0) ? 3'h0 : 3'($urandom_range(1, 7));
         sp = 1'($urandom);
         strap(codes[i], sid, sp);
         chk("stationAddr", {2'h0, sid}, stationAddr);
         chk("rmiiMode", codes[i] == IFSEL_RMII, rmiiMode);
         chk("oe", 7'h7f, {speedIndOe, stationStrapOe, ifSelStrapOe});
         apb(0, ADDR_STAT, 0);
         chk("status", exp_stat(codes[i], sid), rd);
         apb(0, ADDR_CTRL, 0);
         chk("speed", sp, rd[CTRL_SPEED_BIT]);
         apb(0, ADDR_IND, 0);
         chk("mode", IND_MODE_RESET, rd[15:14]);
         chk("indicator", !sp, speed_activity_indicator);
         apb(1, ADDR_IND, 32'h4000);
      end
      strap(IFSEL_MII, 3'h1, 1);
      apb(1, ADDR_CTRL, 32'h0);
      repeat (2) @(negedge sys_clk);
      chk("ind10M", 1, speed_activity_indicator);
      apb(0, 8'h40, 0);
      chk("unmappedErr", 1, err);
      chk("unmappedData", 0, rd);
      apb(1, ADDR_STAT, 32'h1f);
      chk("statusWriteErr", 1, err);
      apb(1, ADDR_IND, 32'h4000);
      repeat (40) @(negedge sys_clk);
      chk("indIdle", 1, speed_activity_indicator);
      toggles = 0;
      repeat (20) rx(4'($urandom));
      chk("indBlink", 1, toggles > 0);
      @(posedge sys_clk);
      recvValid <= 0;
      repeat (30) @(negedge sys_clk);
      chk("rxIdle", 5'h00, {rxValid, rxData});
      apb(1, ADDR_IND, 32'hc000);
      repeat (4) @(negedge sys_clk);
      chk("indReserved", 1, speed_activity_indicator);
      tx(12);
      strap(IFSEL_RMII, 3'h3, 1);
      repeat (8) rx(4'($urandom));
      @(posedge sys_clk);
      recvValid <= 0;
      tx(8);
      complete_run();
   end
endmodule // tb_ppc_pin_cfg
